//--- icc_cfg.svh
// constants for the input capture channel
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH
`define ICC_TSEL_BIT 7
`define ICC_EPI_HI 6
`define ICC_EPI_LO 5
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
`define ICC_CTRL_RESET 16'h0000
`define ICC_DEPTH 4
`define ICC_WIDTH 16
`define ICC_CHANNELS 8
`endif

//--- icc_channel.sv
// one input capture channel
`include "icc_cfg.svh"
module icc_channel (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic capture_pin,
   input wire logic [15:0] capture_control_reg,
   input wire logic stop_in_idle,
   input wire logic capture_irq_enable,
   input wire logic irq_flag_clear,
   input wire logic buffer_read,
   input wire icc_pkg::icc_timers_t timers,
   input wire icc_pkg::icc_power_t power,
   output logic [15:0] capture_data,
   output logic capture_fifo_not_empty,
   output logic capture_overflow_flag,
   output logic capture_irq_flag,
   output logic capture_irq_request,
   output logic wake_request
);
   logic sync_a;
   logic sync_b;
   logic pin_prev;
   logic [3:0] pre_cnt;
   logic [1:0] evt_cnt;
   logic ovf_hold;
   logic [2:0] count;
   logic [15:0] fifo_q;

   // control field decode
   wire [2:0] mode_bits = capture_control_reg[`ICC_MODE_HI:`ICC_MODE_LO];
   wire icc_pkg::icc_mode_t mode = icc_pkg::icc_mode_t'(mode_bits);
   wire tsel = capture_control_reg[`ICC_TSEL_BIT];
   wire [1:0] epi = capture_control_reg[`ICC_EPI_HI:`ICC_EPI_LO];
   wire m_off = (mode == icc_pkg::ICC_OFF);
   wire m_every = (mode == icc_pkg::ICC_EVERY);
   wire m_fall = (mode == icc_pkg::ICC_FALL);
   wire m_rise = (mode == icc_pkg::ICC_RISE);
   wire m_rise4 = (mode == icc_pkg::ICC_RISE4);
   wire m_rise16 = (mode == icc_pkg::ICC_RISE16);
   wire m_wake = (mode == icc_pkg::ICC_WAKE);

   // time base selection
   wire [15:0] tb_val = tsel ? timers.timebase_a : timers.timebase_b;
   wire tb_on = tsel ? timers.timebase_a_on : timers.timebase_b_on;

   // edge detection on the synchronised pin
   wire rise = sync_b && !pin_prev;
   wire fall = !sync_b && pin_prev;
   wire rise_modes = m_rise || m_rise4 || m_rise16 || m_wake;
   wire raw_evt = m_every ? (rise || fall) :
      m_fall ? fall :
      rise_modes ? rise : 1'b0;

   // prescale of rising edges
   wire pre_hit4 = (pre_cnt[1:0] == 2'h3);
   wire pre_hit16 = (pre_cnt == 4'hf);
   wire pre_hit = m_rise4 ? pre_hit4 : m_rise16 ? pre_hit16 : 1'b1;

   // power state qualification
   wire low_power = power.sleep || power.idle;
   wire halted = power.sleep || (power.idle && (stop_in_idle || !tb_on));
   wire int_only = m_wake && low_power;
   wire evt = raw_evt && pre_hit && !halted;
   wire pre_adv = raw_evt && !halted && !int_only;

   // buffer control
   wire full = (count == 3'h4);
   wire pop = buffer_read && (count != 3'h0);
   wire drain_last = (count == 3'h1) && buffer_read;
   wire blocked = ovf_hold && !m_every;
   wire store = evt && !int_only && !blocked && (!full || pop || m_every);
   wire wr_done = store && (!full || pop);
   wire ovf_evt = evt && !int_only && !m_every && full && !buffer_read;

   // interrupt counting
   wire [1:0] next_evt_cnt = evt_cnt + 2'h1;
   wire cnt_done = (evt_cnt == epi);
   wire evt_irq = m_every ? store : cnt_done;
   wire set_irq = (store && evt_irq) || (m_wake && raw_evt);
   wire evt_cnt_adv = store && !m_every;

   // next values of the registered outputs
   wire [2:0] next_count = count + {2'h0, wr_done} - {2'h0, pop};
   wire next_capture_fifo_not_empty = (next_count != 3'h0);
   wire next_capture_overflow_flag = ovf_evt || (ovf_hold && !drain_last);
   wire irq_keep = capture_irq_flag && !irq_flag_clear;
   wire next_capture_irq_flag = set_irq || irq_keep;
   wire next_capture_irq_request = capture_irq_enable && next_capture_irq_flag;
   wire next_wake_request = m_wake && capture_irq_enable && raw_evt && low_power;

   icc_fifo u_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .wr_en(store),
      .wr_data(tb_val),
      .rd_en(buffer_read),
      .rd_data(fifo_q),
      .count(count)
   );

   // pin synchroniser and edge history
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync_a <= 1'b0;
      end else begin
         sync_a <= capture_pin;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync_b <= 1'b0;
      end else begin
         sync_b <= sync_a;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= sync_b;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || m_off) begin
         pre_cnt <= 4'h0;
      end else if (pre_adv) begin
         pre_cnt <= pre_cnt + 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || m_off) begin
         evt_cnt <= 2'h0;
      end else if (evt_cnt_adv) begin
         evt_cnt <= evt_irq ? 2'h0 : next_evt_cnt;
      end
   end

   // overflow held until buffer fully drained
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ovf_hold <= 1'b0;
      end else if (ovf_evt) begin
         ovf_hold <= 1'b1;
      end else if (drain_last) begin
         ovf_hold <= 1'b0;
      end
   end

   // registered outputs, read data holds its last value when empty
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         capture_data <= 16'h0000;
      end else begin
         capture_data <= fifo_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         capture_fifo_not_empty <= 1'b0;
      end else begin
         capture_fifo_not_empty <= next_capture_fifo_not_empty;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         capture_overflow_flag <= 1'b0;
      end else begin
         capture_overflow_flag <= next_capture_overflow_flag;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         capture_irq_flag <= 1'b0;
      end else begin
         capture_irq_flag <= next_capture_irq_flag;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         capture_irq_request <= 1'b0;
      end else begin
         capture_irq_request <= next_capture_irq_request;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= next_wake_request;
      end
   end
endmodule

//--- icc_channel_properties.sv
// assertions on the capture channel ports
module icc_channel_properties (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [15:0] capture_control_reg,
   input wire logic capture_irq_enable,
   input wire logic buffer_read,
   input wire logic [15:0] capture_data,
   input wire logic capture_fifo_not_empty,
   input wire logic capture_overflow_flag,
   input wire logic capture_irq_flag,
   input wire logic capture_irq_request,
   input wire logic wake_request
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_rst; disable iff (1'b0) sys_rst |=> !capture_fifo_not_empty && !wake_request; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_req; capture_irq_request |-> capture_irq_enable || $past(capture_irq_enable); endproperty
   a_req: assert property (p_req) else $error("request without enable");
   property p_wake; wake_request |-> $past(capture_control_reg[2:0]) == 3'b111; endproperty
   a_wake: assert property (p_wake) else $error("wake outside mode 111");
   property p_ovf; $rose(capture_overflow_flag) |-> $past(capture_control_reg[2:0]) != 3'b001; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow in every-edge mode");
   property p_ovne; $rose(capture_overflow_flag) |-> $past(capture_fifo_not_empty); endproperty
   a_ovne: assert property (p_ovne) else $error("overflow with empty buffer");
   property p_fell; $fell(capture_fifo_not_empty) |-> $past(buffer_read); endproperty
   a_fell: assert property (p_fell) else $error("buffer emptied without read");
   property p_data; $changed(capture_data) |-> $past(buffer_read, 2); endproperty
   a_data: assert property (p_data) else $error("data moved without read");
   property p_irq; $rose(capture_irq_flag) |-> $past(capture_control_reg[2:0]) != 3'b000; endproperty
   a_irq: assert property (p_irq) else $error("flag raised while off");
endmodule
bind icc_channel icc_channel_properties i_icc_channel_properties (.*);

//--- icc_fifo.sv
// four-entry shifting capture buffer
`include "icc_cfg.svh"
module icc_fifo (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [`ICC_WIDTH-1:0] wr_data,
   input wire logic rd_en,
   output logic [`ICC_WIDTH-1:0] rd_data,
   output logic [2:0] count
);
   logic [`ICC_WIDTH-1:0] mem [0:`ICC_DEPTH-1];
   wire full = (count == 3'h4);
   wire do_rd = rd_en && (count != 3'h0);
   wire do_wr = wr_en && (!full || do_rd);
   wire [2:0] slot = do_rd ? count - 3'h1 : count;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count <= 3'h0;
      end else begin
         count <= count + {2'h0, do_wr} - {2'h0, do_rd};
      end
   end
   genvar i;
   generate
      for (i = 0; i < `ICC_DEPTH; i = i + 1) begin : g_ent
         always_ff @(posedge mclk) begin
            if (do_wr && slot == 3'(i)) begin
               mem[i] <= wr_data;
            end else if (do_rd && i < `ICC_DEPTH - 1) begin
               mem[i] <= mem[(i + 1) % `ICC_DEPTH];
            end
         end
      end
   endgenerate
   // head entry registered for read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_data <= 16'h0000;
      end else if (do_rd) begin
         rd_data <= mem[0];
      end
   end
endmodule

//--- icc_pin_model.sv
// external edge source on the capture pin
module icc_pin_model (
   input wire logic mclk,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin = 1'b0;
   task automatic pulse;
      pin <= 1'b1;
      repeat (4) @(posedge mclk);
      pin <= 1'b0;
   endtask
endmodule

//--- icc_pkg.sv
// types for the input capture channel
package icc_pkg;
   typedef enum logic [2:0] {
      ICC_OFF = 3'b000,
      ICC_EVERY = 3'b001,
      ICC_FALL = 3'b010,
      ICC_RISE = 3'b011,
      ICC_RISE4 = 3'b100,
      ICC_RISE16 = 3'b101,
      ICC_RSVD = 3'b110,
      ICC_WAKE = 3'b111
   } icc_mode_t;
   typedef struct packed {
      logic [15:0] timebase_a;
      logic [15:0] timebase_b;
      logic timebase_a_on;
      logic timebase_b_on;
   } icc_timers_t;
   typedef struct packed {
      logic sleep;
      logic idle;
   } icc_power_t;
endpackage

//--- input_capture_channel_bench.sv
// self-checking bench for the capture channel
module input_capture_channel_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, sys_rst, ien, clr, rd, pin, ne, ovf, irq, req, wake, sidl;
   logic [15:0] ctrl, data, lf;
   icc_pkg::icc_timers_t tm;
   icc_pkg::icc_power_t pw;
   int n_errors, n_tests, n_wake;
   logic [15:0] q[$];
   bit blk, sawo;
   icc_channel i_icc_channel (.mclk(mclk), .sys_rst(sys_rst), .capture_pin(pin),
      .capture_control_reg(ctrl), .stop_in_idle(sidl), .capture_irq_enable(ien),
      .irq_flag_clear(clr), .buffer_read(rd), .timers(tm), .power(pw), .capture_data(data),
      .capture_fifo_not_empty(ne), .capture_overflow_flag(ovf), .capture_irq_flag(irq),
      .capture_irq_request(req), .wake_request(wake));
   icc_pin_model i_icc_pin_model (.mclk(mclk), .pin(pin));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) if (wake === 1'b1) n_wake++;
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic rst(input logic [15:0] c, input logic [1:0] p);
      sys_rst <= 1'b1;
      ctrl <= c;
      pw <= p;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      q.delete();
      blk = 0;
      sawo = 0;
      @(posedge mclk);
   endtask
   task automatic ev(input int n);
      lf = nxt(lf);
      tm <= '{lf, ~lf, 1'b1, 1'b1};
      i_icc_pin_model.pulse();
      repeat (8) @(posedge mclk);
      for (int i = 0; i < n; i++)
         if (q.size() == 4 && ctrl[2:0] != 3'b001) {blk, sawo} = 2'b11;
         else if (q.size() < 4 && !blk) q.push_back(ctrl[7] ? lf : ~lf);
      chk("not_empty", 16'(q.size() != 0), 16'(ne));
      if (blk || !sawo) chk("overflow", 16'(blk), 16'(ovf));
   endtask
   task automatic rd1;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("data", q.pop_front(), data);
      if (q.size() == 0) blk = 0;
   endtask
   initial begin
      {sys_rst, ien, clr, rd, ctrl, tm, pw, lf} = {4'b1100, 16'h0000, 34'h0, 2'b00, 16'h000e};
      sidl = 1'b0;
      rst(16'h0083, 2'b00);
      repeat (6) ev(1);
      repeat (4) rd1();
      ev(1);
      rd1();
      rst(16'h0003, 2'b00);
      ev(1);
      rd1();
      rst(16'h0063, 2'b00);
      repeat (3) ev(1);
      chk("irq", 16'h0000, 16'(irq));
      ev(1);
      chk("irq", 16'h0001, 16'(irq));
      chk("req", 16'h0001, 16'(req));
      clr <= 1'b1;
      ien <= 1'b0;
      repeat (2) @(posedge mclk);
      clr <= 1'b0;
      @(posedge mclk);
      chk("req", 16'h0000, 16'(req));
      chk("irq", 16'h0000, 16'(irq));
      rst(16'h0061, 2'b00);
      ev(2);
      chk("irq", 16'h0001, 16'(irq));
      repeat (2) ev(2);
      chk("irq", 16'h0001, 16'(irq));
      repeat (4) rd1();
      sidl <= 1'b1;
      rst(16'h0003, 2'b01);
      ev(0);
      sidl <= 1'b0;
      ev(1);
      rd1();
      ien <= 1'b1;
      rst(16'h0007, 2'b01);
      ev(0);
      rst(16'h0007, 2'b10);
      ev(0);
      chk("wake", 16'h0002, 16'(n_wake));
      results();
   end
endmodule
